// ===== hw/arss_line_delay.sv
// per-line start delay counters for the pending shot
`timescale 1ns/100ps
module arss_line_delay (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // control
  input  wire logic [3:0]  i_line,
  input  wire logic [3:0]  i_arm,
  input  wire logic        i_clear,
  input  wire logic [63:0] i_delay,
  // status
  output logic [3:0]       o_ripe
);
  typedef struct packed {
    logic [3:0][15:0] cnt;
    logic [3:0]       ripe;
  } arss_dly_type;
  arss_dly_type s_reg, s_next;

  // each line times alone; a drop restarts from zero
  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < 4; i++) begin
      if (i_clear || !i_line[i] || !i_arm[i]) begin
        s_next.cnt[i]  = 16'h0;
        s_next.ripe[i] = 1'b0;
      end else if (s_reg.cnt[i] >= i_delay[i*16 +: 16]) begin
        s_next.ripe[i] = 1'b1;
      end else begin
        s_next.cnt[i] = s_reg.cnt[i] + 16'h1;
        s_next.ripe[i] = ((s_reg.cnt[i] + 16'h1) >= i_delay[i*16 +: 16]);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_ripe = s_reg.ripe;
endmodule

// ===== hw/arss_map.svh
// constants for the auto-reclose shot sequencer
`ifndef ARSS_MAP_SVH
`define ARSS_MAP_SVH
// register offsets
`define ARSS_OFS_CTRL      8'h00
`define ARSS_OFS_STATUS    8'h04
`define ARSS_OFS_INT_STAT  8'h08
`define ARSS_OFS_INT_MASK  8'h0c
`define ARSS_OFS_TD        8'h10
`define ARSS_OFS_TR        8'h14
`define ARSS_OFS_DEAD      8'h18
`define ARSS_OFS_ACT_BASE  8'h40
`define ARSS_OFS_DLY_BASE  8'h80
`define ARSS_OFS_ACT_END   8'h58
`define ARSS_OFS_DLY_END   8'hb0
// field positions
`define ARSS_CTRL_SRC_BIT  0
`define ARSS_CTRL_EN_BIT   1
// action encodings
`define ARSS_ACT_NONE      2'h0
`define ARSS_ACT_START     2'h1
`define ARSS_ACT_BLOCK     2'h2
// pointer values
`define ARSS_PTR_FIRST     3'h1
`define ARSS_PTR_LAST      3'h5
`define ARSS_PTR_FINAL     3'h6
`define ARSS_PTR_LOCK      3'h7
// event bits
`define ARSS_EV_OPEN       0
`define ARSS_EV_CLOSE      1
`define ARSS_EV_LOCK       2
`define ARSS_EV_DISC       3
// reset values (timer counts in clock cycles)
`define ARSS_TD_RESET      32'h0000_0000
`define ARSS_TR_RESET      32'h0000_1000
`define ARSS_DEAD_RESET    32'h0000_0100
`endif

// ===== hw/arss_pkg.sv
// types of the auto-reclose shot sequencer
package arss_pkg;
  typedef logic [1:0] arss_act_type;
  typedef logic [2:0] arss_ptr_type;
  typedef logic [31:0] arss_word_type;
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_OPEN, ST_DEAD, ST_CLOSE} arss_state_type;
endpackage

// ===== hw/arss_sequencer.sv
// auto-reclose shot sequencer top level
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "arss_map.svh"
module arss_sequencer (
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  // register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output arss_pkg::arss_word_type     o_rdata,
  // initiation lines
  input  wire logic                   i_reclose_request_line_1,
  input  wire logic                   i_reclose_request_line_2,
  input  wire logic                   i_reclose_request_line_3,
  input  wire logic                   i_reclose_request_line_4,
  // breaker
  input  wire logic                   i_breaker_position_input,
  output logic                        o_breaker_open,
  output logic                        o_breaker_close,
  // status
  output arss_pkg::arss_ptr_type      o_shot_pointer,
  output logic                        o_irq
);
  import arss_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    arss_state_type   st;
    arss_ptr_type     ptr;
    arss_ptr_type     tgt;
    logic [1:0]       ctrl;
    logic [5:0][7:0]  act;
    logic [5:0][63:0] dly;
    logic [31:0]      td;
    logic [31:0]      tr;
    logic [31:0]      dead;
    logic [31:0]      dead_cnt;
    logic [3:0]       ist;
    logic [3:0]       imask;
    logic             open_o;
    logic             close_o;
    logic             irq;
    logic             lock_pend;
    logic             pos_q;
    logic [31:0]      rdata;
  } arss_core_type;
  arss_core_type s_reg, s_next;

  logic [3:0] line;
  assign line = {i_reclose_request_line_4, i_reclose_request_line_3,
                 i_reclose_request_line_2, i_reclose_request_line_1};

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // action of line l for pointer p (1..6)
  function automatic logic [1:0] act_of(input logic [5:0][7:0] a,
                                        input logic [2:0] p, input int l);
    logic [2:0] idx;
    idx = p - 3'h1;
    return a[idx][l*2 +: 2];
  endfunction

  function automatic logic [3:0] lines_with(input logic [5:0][7:0] a,
                                            input logic [2:0] p,
                                            input logic [1:0] code);
    logic [3:0] m;
    m = 4'h0;
    for (int l = 0; l < 4; l++) begin
      m[l] = (act_of(a, p, l) == code);
    end
    return m;
  endfunction

  // register window decode, shared by writes and reads
  function automatic logic is_act_addr(input logic [7:0] a);
    return (a >= `ARSS_OFS_ACT_BASE) && (a < `ARSS_OFS_ACT_END) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_dly_addr(input logic [7:0] a);
    return (a >= `ARSS_OFS_DLY_BASE) && (a < `ARSS_OFS_DLY_END) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // shot selection
  // ----------------------------------------------------------------
  arss_ptr_type sel;
  arss_ptr_type sel_c;
  logic         sel_ok;
  always_comb begin
    sel = s_reg.ptr;
    sel_ok = 1'b0;
    for (int p = 6; p >= 1; p--) begin
      if (p[2:0] >= s_reg.ptr && s_reg.ptr <= `ARSS_PTR_FINAL) begin
        if ((|(line & lines_with(s_reg.act, p[2:0], `ARSS_ACT_START))) &&
            !(|(line & lines_with(s_reg.act, p[2:0], `ARSS_ACT_BLOCK)))) begin
          sel = p[2:0];
          sel_ok = 1'b1;
        end
      end
    end
  end

  // lock-out pointer has no action row, so clamp before indexing
  assign sel_c = (sel > `ARSS_PTR_FINAL) ? `ARSS_PTR_FINAL : sel;

  // ----------------------------------------------------------------
  // start delay and timers
  // ----------------------------------------------------------------
  logic [3:0] ripe;
  logic [3:0] arm;
  logic       dly_clear;
  logic       td_run, tr_run, tr_done;
  logic       close_ev;
  logic       disc_hit;

  // delay armed by Start lines only, blocks do not touch it
  assign arm = lines_with(s_reg.act, sel_c, `ARSS_ACT_START);
  // lock-out clears the counters so a new sequence times from zero
  assign dly_clear = (s_reg.st != ST_IDLE) || (s_reg.ptr == `ARSS_PTR_LOCK) ||
                     (!sel_ok && !(|line));
  assign close_ev = s_reg.pos_q && !i_breaker_position_input;
  // redirect once; the final trip then runs on its own start delay
  assign disc_hit = td_run && (|line) && (s_reg.ptr < `ARSS_PTR_FINAL);

  // one delay set per pointer value
  arss_line_delay u_delay (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_line    (line),
    .i_arm     (arm),
    .i_clear   (dly_clear),
    .i_delay   (s_reg.dly[sel_c - 3'h1]),
    .o_ripe    (ripe)
  );

  arss_timer u_td (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (close_ev && s_reg.td != 32'h0 && s_reg.st == ST_CLOSE),
    .i_stop    (s_reg.td == 32'h0),
    .i_load    (s_reg.td),
    .o_run     (td_run),
    .o_done    ()
  );

  arss_timer u_tr (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (close_ev),
    .i_stop    (1'b0),
    .i_load    (s_reg.tr),
    .o_run     (tr_run),
    .o_done    (tr_done)
  );

  // ----------------------------------------------------------------
  // main process
  // ----------------------------------------------------------------
  logic [3:0] ev;
  always_comb begin
    s_next = s_reg;
    ev = 4'h0;
    s_next.pos_q = i_breaker_position_input;
    s_next.open_o = 1'b0;
    s_next.close_o = 1'b0;
    s_next.rdata = 32'h0;

    case (s_reg.st)
      ST_IDLE: begin
        if (s_reg.ctrl[`ARSS_CTRL_EN_BIT] && s_reg.ptr != `ARSS_PTR_LOCK) begin
          if (disc_hit) begin
            s_next.ptr = `ARSS_PTR_FINAL;
            ev[`ARSS_EV_DISC] = 1'b1;
          end else if (sel_ok) begin
            // pointer untouched here; tgt carries the shot until its close or lock-out
            if (!s_reg.ctrl[`ARSS_CTRL_SRC_BIT]) begin
              // trip based, no delay, protection opens
              s_next.tgt = sel;
              s_next.st = ST_OPEN;
            end else if (|(ripe & line & arm)) begin
              s_next.tgt = sel;
              s_next.open_o = 1'b1;
              s_next.st = ST_OPEN;
            end
          end
        end
      end
      ST_OPEN: begin
        s_next.open_o = s_reg.ctrl[`ARSS_CTRL_SRC_BIT];
        if (i_breaker_position_input) begin
          s_next.open_o = 1'b0;
          ev[`ARSS_EV_OPEN] = 1'b1;
          if (s_reg.tgt == `ARSS_PTR_FINAL) begin
            s_next.ptr = `ARSS_PTR_LOCK;
            ev[`ARSS_EV_LOCK] = 1'b1;
            s_next.st = ST_IDLE;
          end else begin
            s_next.dead_cnt = s_reg.dead;
            s_next.st = ST_DEAD;
          end
        end
      end
      ST_DEAD: begin
        if (s_reg.dead_cnt == 32'h0) begin
          s_next.close_o = 1'b1;
          s_next.st = ST_CLOSE;
        end else begin
          s_next.dead_cnt = s_reg.dead_cnt - 32'h1;
        end
      end
      ST_CLOSE: begin
        s_next.close_o = 1'b1;
        if (!i_breaker_position_input) begin
          s_next.close_o = 1'b0;
          ev[`ARSS_EV_CLOSE] = 1'b1;
          // next shot armed for reclaim period
          if (s_reg.tgt == `ARSS_PTR_LAST) begin
            s_next.ptr = `ARSS_PTR_LOCK;
            ev[`ARSS_EV_LOCK] = 1'b1;
          end else begin
            s_next.ptr = s_reg.tgt + 3'h1;
          end
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    if (tr_done && s_reg.st == ST_IDLE && !disc_hit) begin
      s_next.ptr = `ARSS_PTR_FIRST;
    end

    // register writes
    if (i_wr) begin
      case (i_addr)
        `ARSS_OFS_CTRL:     s_next.ctrl = i_wdata[1:0];
        `ARSS_OFS_INT_MASK: s_next.imask = i_wdata[3:0];
        `ARSS_OFS_TD:       s_next.td = i_wdata;
        `ARSS_OFS_TR:       s_next.tr = i_wdata;
        `ARSS_OFS_DEAD:     s_next.dead = i_wdata;
        default: begin
          if (is_act_addr(i_addr)) begin
            s_next.act[(i_addr - `ARSS_OFS_ACT_BASE) >> 2] = i_wdata[7:0];
          end
          if (is_dly_addr(i_addr)) begin
            s_next.dly[(i_addr - `ARSS_OFS_DLY_BASE) >> 3][i_addr[2] * 32 +: 32] = i_wdata;
          end
        end
      endcase
    end

    // sticky events, set wins over write-one clear
    if (i_wr && i_addr == `ARSS_OFS_INT_STAT) begin
      s_next.ist = (s_reg.ist & ~i_wdata[3:0]) | ev;
    end else begin
      s_next.ist = s_reg.ist | ev;
    end
    s_next.irq = |(s_next.ist & s_next.imask);

    // register reads, data next cycle
    if (i_rd) begin
      case (i_addr)
        `ARSS_OFS_CTRL:     s_next.rdata = {30'h0, s_reg.ctrl};
        `ARSS_OFS_STATUS:   s_next.rdata = {24'h0, td_run, tr_run, s_reg.st, s_reg.ptr};
        `ARSS_OFS_INT_STAT: s_next.rdata = {28'h0, s_reg.ist};
        `ARSS_OFS_INT_MASK: s_next.rdata = {28'h0, s_reg.imask};
        `ARSS_OFS_TD:       s_next.rdata = s_reg.td;
        `ARSS_OFS_TR:       s_next.rdata = s_reg.tr;
        `ARSS_OFS_DEAD:     s_next.rdata = s_reg.dead;
        default: begin
          if (is_act_addr(i_addr)) begin
            s_next.rdata = {24'h0, s_reg.act[(i_addr - `ARSS_OFS_ACT_BASE) >> 2]};
          end
          if (is_dly_addr(i_addr)) begin
            s_next.rdata = s_reg.dly[(i_addr - `ARSS_OFS_DLY_BASE) >> 3][i_addr[2] * 32 +: 32];
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.ptr <= `ARSS_PTR_FIRST;
      s_reg.tgt <= `ARSS_PTR_FIRST;
      s_reg.td <= `ARSS_TD_RESET;
      s_reg.tr <= `ARSS_TR_RESET;
      s_reg.dead <= `ARSS_DEAD_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign o_rdata         = s_reg.rdata;
  assign o_breaker_open  = s_reg.open_o;
  assign o_breaker_close = s_reg.close_o;
  assign o_shot_pointer  = s_reg.ptr;
  assign o_irq           = s_reg.irq;
endmodule

// ===== hw/arss_timer.sv
// reusable down-counting timer, restartable
`timescale 1ns/100ps
module arss_timer (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // control
  input  wire logic        i_start,
  input  wire logic        i_stop,
  input  wire logic [31:0] i_load,
  // status
  output logic             o_run,
  output logic             o_done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        done;
  } arss_tmr_type;
  arss_tmr_type s_reg, s_next;

  // count down, pulse done at zero
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (i_stop) begin
      s_next.run = 1'b0;
    end else if (i_start) begin
      s_next.cnt = i_load;
      s_next.run = (i_load != 32'h0);
      s_next.done = (i_load == 32'h0);
    end else if (s_reg.run) begin
      if (s_reg.cnt <= 32'h1) begin
        s_next.run = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_run  = s_reg.run;
  assign o_done = s_reg.done;
endmodule

// ===== verification/arss_breaker_model.sv
// breaker model facing the shot sequencer
`timescale 1ns/100ps
module arss_breaker_model (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  // commands
  input  wire logic       i_open,
  input  wire logic       i_close,
  input  wire logic       i_trip,
  input  wire logic [3:0] i_lat,
  // position
  output logic            o_pos
);
  logic [3:0] cnt_reg;
  // moves after i_lat+1 cycles of a held command
  // protection trip, high when open
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pos   <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (i_trip) begin
      o_pos <= 1'b1;
    end else if ((i_open && !o_pos) || (i_close && o_pos)) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg >= i_lat) begin
        o_pos   <= ~o_pos;
        cnt_reg <= 4'h0;
      end
    end else begin
      cnt_reg <= 4'h0;
    end
  end
endmodule

// ===== verification/arss_sequencer_sva.sv
// port checker of the shot sequencer
`timescale 1ns/100ps
module arss_sequencer_sva (
  // clock and reset
  input wire logic                  i_ref_clk,
  input wire logic                  i_sys_rst,
  // register port
  input wire logic [7:0]            i_addr,
  input wire logic [31:0]           i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire arss_pkg::arss_word_type o_rdata,
  // lines and breaker
  input wire logic                  i_reclose_request_line_1,
  input wire logic                  i_reclose_request_line_2,
  input wire logic                  i_reclose_request_line_3,
  input wire logic                  i_reclose_request_line_4,
  input wire logic                  i_breaker_position_input,
  input wire logic                  o_breaker_open,
  input wire logic                  o_breaker_close,
  input wire arss_pkg::arss_ptr_type o_shot_pointer,
  input wire logic                  o_irq
);
  import arss_pkg::*;
  logic any_line;
  // any initiation line high
  assign any_line = i_reclose_request_line_1 | i_reclose_request_line_2 |
                    i_reclose_request_line_3 | i_reclose_request_line_4;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // recent causes
  sequence line_recent;
    $past(any_line) || $past(any_line, 2);
  endsequence
  sequence close_recent;
    $past(o_breaker_close) || $past(o_breaker_close, 2) || $past(o_breaker_close, 3);
  endsequence
  open_cause_a: assert property ($rose(o_breaker_open) |-> line_recent)
    else $error("open command without a line");
  open_hold_a: assert property (o_breaker_open && !i_breaker_position_input |=> o_breaker_open)
    else $error("open command dropped early");
  close_hold_a: assert property (o_breaker_close && i_breaker_position_input |=> o_breaker_close)
    else $error("close command dropped early");
  cmd_excl_a: assert property (!(o_breaker_open && o_breaker_close))
    else $error("open and close together");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  ptr_step_a: assert property ($changed(o_shot_pointer) &&
    o_shot_pointer inside {[3'h2:3'h5]} |-> close_recent)
    else $error("pointer moved without a close");
  disc_jump_a: assert property ($changed(o_shot_pointer) &&
    o_shot_pointer == 3'h6 |-> line_recent)
    else $error("final trip without a line");
  lock_exit_a: assert property ($past(o_shot_pointer) == 3'h7 &&
    o_shot_pointer != 3'h7 |-> o_shot_pointer == 3'h1)
    else $error("lock-out left to wrong pointer");
  lock_quiet_a: assert property (o_shot_pointer == 3'h7 &&
    $past(o_shot_pointer) == 3'h7 |-> !$rose(o_breaker_open))
    else $error("open command in lock-out");
endmodule
bind arss_sequencer arss_sequencer_sva arss_sequencer_sva_i (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_reclose_request_line_1(i_reclose_request_line_1),
  .i_reclose_request_line_2(i_reclose_request_line_2),
  .i_reclose_request_line_3(i_reclose_request_line_3),
  .i_reclose_request_line_4(i_reclose_request_line_4),
  .i_breaker_position_input(i_breaker_position_input),
  .o_breaker_open(o_breaker_open), .o_breaker_close(o_breaker_close),
  .o_shot_pointer(o_shot_pointer), .o_irq(o_irq)
);

// ===== verification/tb.sv
// self-checking bench of the shot sequencer
`timescale 1ns/100ps
module tb;
  import arss_pkg::*;
  logic          clk, rst, wr, rd, trip, pos, opn, cls, irq;
  logic [7:0]    addr;
  logic [31:0]   wdata;
  logic [3:0]    ln, lat;
  arss_word_type rdata;
  arss_ptr_type  ptr;
  int            num_errors, cmp_count;
  // design and breaker model
  arss_sequencer arss_sequencer_i (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_reclose_request_line_1(ln[0]), .i_reclose_request_line_2(ln[1]),
    .i_reclose_request_line_3(ln[2]), .i_reclose_request_line_4(ln[3]),
    .i_breaker_position_input(pos), .o_breaker_open(opn),
    .o_breaker_close(cls), .o_shot_pointer(ptr), .o_irq(irq)
  );
  arss_breaker_model arss_breaker_model_i (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_open(opn), .i_close(cls),
    .i_trip(trip), .i_lat(lat), .o_pos(pos)
  );
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done();
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // waits for open (k=0) or close (k=1)
  task automatic wev(input int k, input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 hit = (k == 0) ? opn : cls;
      if (hit === 1'b1) break;
    end
    chk(32'(hit), 32'h1);
  endtask
  task automatic wptr(input arss_ptr_type p, input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (ptr === p) break;
    end
    chk(32'(ptr), 32'(p));
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 seen = seen | opn;
    end
    chk(32'(seen), 32'h0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rreg(8'h04, 32'h1);
    rreg(8'h14, 32'h1000);
    rreg(8'h18, 32'h100);
    rreg(8'h10, 32'h0);
    wreg(8'h3c, 32'hffff_ffff);
    rreg(8'h3c, 32'h0);
    wreg(8'h0c, 32'hf);
    rreg(8'h0c, 32'hf);
  endtask
  task automatic t_cfg();
    wreg(8'h14, 32'h12c);
    wreg(8'h18, 32'h6);
    wreg(8'h40, 32'h19);
    wreg(8'h44, 32'h40);
    wreg(8'h54, 32'h40);
    wreg(8'h80, 32'h0030_000a);
    wreg(8'h84, 32'h64);
    wreg(8'h8c, 32'h0);
    wreg(8'hac, 32'h0);
    rreg(8'h40, 32'h19);
    rreg(8'h80, 32'h0030_000a);
  endtask
  task automatic t_trip();
    wreg(8'h00, 32'h2);
    @(posedge clk) ln <= 4'h4;
    @(posedge clk) trip <= 1'b1;
    @(posedge clk) trip <= 1'b0;
    ln <= 4'h0;
    quiet(3);
    wev(1, 40);
    wptr(3'h2, 10);
    wptr(3'h1, 400);
  endtask
  task automatic t_drop();
    wreg(8'h00, 32'h3);
    @(posedge clk) ln <= 4'h1;
    repeat (5) @(posedge clk);
    ln <= 4'h0;
    @(posedge clk) ln <= 4'h1;
    repeat (7) @(posedge clk);
    ln <= 4'h0;
    quiet(15);
  endtask
  task automatic t_block();
    @(posedge clk) ln <= 4'h1;
    repeat (3) @(posedge clk);
    ln <= 4'h3;
    quiet(20);
    chk(32'(ptr), 32'h1);
    @(posedge clk) ln <= 4'h1;
    wev(0, 4);
    @(posedge clk) ln <= 4'h0;
    wev(1, 40);
    wptr(3'h2, 10);
    rreg(8'h08, 32'h3);
    #1 chk(32'(irq), 32'h1);
    wreg(8'h08, 32'h3);
    @(posedge clk) #1 chk(32'(irq), 32'h0);
  endtask
  task automatic t_reclaim();
    wreg(8'h0c, 32'h0);
    lat <= 4'h6;
    @(posedge clk) ln <= 4'h8;
    wev(0, 4);
    @(posedge clk) ln <= 4'h0;
    wreg(8'h10, 32'h28);
    wev(1, 60);
    wptr(3'h3, 10);
    rreg(8'h04, 32'hc3);
    rreg(8'h08, 32'h3);
    chk(32'(irq), 32'h0);
    wreg(8'h0c, 32'hf);
    @(posedge clk) #1 chk(32'(irq), 32'h1);
    wreg(8'h08, 32'h3);
  endtask
  task automatic t_disc();
    @(posedge clk) ln <= 4'h8;
    wptr(3'h6, 6);
    wev(0, 4);
    wptr(3'h7, 30);
    rreg(8'h08, 32'hd);
    quiet(20);
    @(posedge clk) ln <= 4'h0;
    wptr(3'h1, 400);
  endtask
  // main sequence
  initial begin
    rst        = 1'b1;
    wr         = 1'b0;
    rd         = 1'b0;
    trip       = 1'b0;
    addr       = 8'h0;
    wdata      = 32'h0;
    ln         = 4'h0;
    lat        = 4'h2;
    num_errors = 0;
    cmp_count  = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cfg();
    t_trip();
    t_drop();
    t_block();
    t_reclaim();
    t_disc();
    test_done();
  end
endmodule
